// ### core/swb_pkg.sv
// Constants for the reverse subtract-with-borrow datapath and its APB map.
// Assumes a single 125 MHz clock and an asynchronous active-low reset.
`default_nettype none

package swb_pkg;

  // ==========================================================
  // Widths
  localparam int DATA_W = 8;
  localparam int MADDR_W = 12;
  localparam int MEM_DEPTH = 4096;
  localparam int PADDR_W = 8;

  // ==========================================================
  // APB byte offsets
  localparam logic [PADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [PADDR_W-1:0] OFF_INSTR = 8'h04;
  localparam logic [PADDR_W-1:0] OFF_WREG = 8'h08;
  localparam logic [PADDR_W-1:0] OFF_STATUS = 8'h0c;
  localparam logic [PADDR_W-1:0] OFF_BANK = 8'h10;
  localparam logic [PADDR_W-1:0] OFF_INDEX = 8'h14;
  localparam logic [PADDR_W-1:0] OFF_MADDR = 8'h18;
  localparam logic [PADDR_W-1:0] OFF_MDATA = 8'h1c;

  // ==========================================================
  // Control register fields
  localparam int CTRL_START = 0;
  localparam int CTRL_EXT = 1;
  localparam int CTRL_BUSY = 8;
  localparam int CTRL_ILLEGAL = 9;

  // ==========================================================
  // Instruction fields
  localparam logic [5:0] OPC_PREFIX = 6'h15;
  localparam int INS_DEST = 9;
  localparam int INS_BANK = 8;
  localparam logic [7:0] IDX_LIMIT = 8'h5f;
  localparam logic [3:0] WIN_HIGH_PAGE = 4'hf;

  // ==========================================================
  // Status flag positions
  localparam int FLG_C = 0;
  localparam int FLG_DC = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_OV = 3;
  localparam int FLG_N = 4;

  // ==========================================================
  // Reset values
  localparam logic [15:0] RST_INSTR = 16'h0000;
  localparam logic [7:0] RST_WREG = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [3:0] RST_BANK = 4'h0;
  localparam logic [11:0] RST_INDEX = 12'h000;

  // ==========================================================
  // Phase sequence, Gray from ST_IDLE through ST_Q4; the return from ST_Q4 to ST_IDLE changes two bits
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_Q1 = 3'b001,
    ST_Q2 = 3'b011,
    ST_Q3 = 3'b010,
    ST_Q4 = 3'b110
  } swb_state_e;

endpackage : swb_pkg

`default_nettype wire

// ### core/swb_mem.sv
// Banked data memory, one port, read data registered.
// Assumes the caller keeps the address stable for the read to be valid.
`default_nettype none

module swb_mem
  import swb_pkg::*;
(
  // Clock
  input wire logic pclk,
  input wire logic presetn,
  // Port
  input wire logic we,
  input wire logic [swb_pkg::MADDR_W-1:0] addr,
  input wire logic [swb_pkg::DATA_W-1:0] wdata,
  output logic [swb_pkg::DATA_W-1:0] rdata
);

  typedef struct packed {
    logic [DATA_W-1:0] rdata;
  } swb_mem_s;

  logic [DATA_W-1:0] mem [MEM_DEPTH];
  swb_mem_s s;
  swb_mem_s next_s;

  always_comb begin
    next_s = s;
    next_s.rdata = mem[addr];
  end

  // Array kept outside reset; contents are undefined until written
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rdata = s.rdata;

endmodule : swb_mem

`default_nettype wire

// ### core/swb_core.sv
// Reverse subtract-with-borrow execution unit with an APB register slave.
// Assumes an APB master on pclk; every transfer sees one wait state.
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`default_nettype none

module swb_core (
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB request
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [swb_pkg::PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  // APB answer
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr
);
  import swb_pkg::*;

  typedef struct packed {
    swb_state_e st;
    logic [15:0] instr;
    logic [7:0] wreg;
    logic [7:0] status;
    logic [3:0] bank;
    logic [11:0] idx;
    logic [11:0] maddr;
    logic ext;
    logic illegal;
    logic dest;
    logic [11:0] addr;
    logic [7:0] res;
    logic [4:0] flg;
    logic idle_d;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } swb_regs_s;

  swb_regs_s s;
  swb_regs_s next_s;

  logic mem_we;
  logic [MADDR_W-1:0] mem_addr;
  logic [DATA_W-1:0] mem_wdata;
  logic [DATA_W-1:0] mem_rdata;
  logic [4:0] lo_sum;
  logic [8:0] full_sum;
  logic busy;
  logic apb_wait;
  logic apb_done;
  logic [7:0] ffield;

  // ==========================================================
  // Arithmetic
  // W + ~f + C is W - f - !C in two's complement
  assign lo_sum = {1'b0, s.wreg[3:0]} + {1'b0, ~mem_rdata[3:0]}
                + {4'h0, s.status[FLG_C]};
  assign full_sum = {1'b0, s.wreg} + {1'b0, ~mem_rdata}
                  + {8'h00, s.status[FLG_C]};

  assign busy = (s.st != ST_IDLE);
  assign apb_wait = psel && penable && !s.pready;
  assign apb_done = psel && penable && s.pready;
  assign ffield = s.instr[7:0];

  swb_mem u_mem (
    .pclk(pclk),
    .presetn(presetn),
    .we(mem_we),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );

  // ==========================================================
  // Next state
  always_comb begin
    next_s = s;
    mem_we = 1'b0;
    mem_addr = s.maddr;
    mem_wdata = pwdata[7:0];
    next_s.idle_d = !busy;

    // APB: answer prepared in the wait cycle, applied a cycle later
    if (apb_wait) begin
      next_s.pready = 1'b1;
      next_s.pslverr = 1'b0;
      next_s.prdata = 32'h0000_0000;
      // Writes while executing would race the phase-four update
      if (pwrite && busy) begin
        next_s.pslverr = 1'b1;
      end else if (paddr == OFF_CTRL) begin
        next_s.prdata[CTRL_EXT] = s.ext;
        next_s.prdata[CTRL_BUSY] = busy;
        next_s.prdata[CTRL_ILLEGAL] = s.illegal;
      end else if (paddr == OFF_INSTR) begin
        next_s.prdata[15:0] = s.instr;
      end else if (paddr == OFF_WREG) begin
        next_s.prdata[7:0] = s.wreg;
      end else if (paddr == OFF_STATUS) begin
        next_s.prdata[7:0] = s.status;
      end else if (paddr == OFF_BANK) begin
        next_s.prdata[3:0] = s.bank;
      end else if (paddr == OFF_INDEX) begin
        next_s.prdata[11:0] = s.idx;
      end else if (paddr == OFF_MADDR) begin
        next_s.prdata[11:0] = s.maddr;
      end else if (paddr == OFF_MDATA) begin
        // Read data only trusted after a full idle cycle
        if (busy || !s.idle_d) begin
          next_s.pslverr = pwrite ? 1'b0 : 1'b1;
        end else begin
          next_s.prdata[7:0] = mem_rdata;
        end
      end else begin
        next_s.pslverr = 1'b1;
      end
    end else if (apb_done) begin
      next_s.pready = 1'b0;
      next_s.pslverr = 1'b0;
      if (pwrite && !s.pslverr) begin
        if (paddr == OFF_CTRL) begin
          next_s.ext = pwdata[CTRL_EXT];
          if (pwdata[CTRL_START]) begin
            next_s.st = ST_Q1;
            next_s.illegal = 1'b0;
          end
        end else if (paddr == OFF_INSTR) begin
          next_s.instr = pwdata[15:0];
        end else if (paddr == OFF_WREG) begin
          next_s.wreg = pwdata[7:0];
        end else if (paddr == OFF_STATUS) begin
          next_s.status = pwdata[7:0];
        end else if (paddr == OFF_BANK) begin
          next_s.bank = pwdata[3:0];
        end else if (paddr == OFF_INDEX) begin
          next_s.idx = pwdata[11:0];
        end else if (paddr == OFF_MADDR) begin
          next_s.maddr = pwdata[11:0];
        end else if (paddr == OFF_MDATA) begin
          mem_we = 1'b1;
        end
      end
    end

    // Instruction phases
    case (s.st)
      ST_IDLE: begin
        // A start from the bus above picks the next state
      end
      ST_Q1: begin
        if (s.instr[15:10] == OPC_PREFIX) begin
          next_s.dest = s.instr[INS_DEST];
          next_s.st = ST_Q2;
          if (s.instr[INS_BANK]) begin
            next_s.addr = {s.bank, ffield};
          end else if (s.ext && ffield <= IDX_LIMIT) begin
            next_s.addr = s.idx + {4'h0, ffield};
          end else if (ffield <= IDX_LIMIT) begin
            next_s.addr = {4'h0, ffield};
          end else begin
            next_s.addr = {WIN_HIGH_PAGE, ffield};
          end
        end else begin
          next_s.illegal = 1'b1;
          next_s.st = ST_IDLE;
        end
      end
      ST_Q2: begin
        mem_addr = s.addr;
        next_s.st = ST_Q3;
      end
      ST_Q3: begin
        next_s.res = full_sum[7:0];
        next_s.flg[FLG_C] = full_sum[8];
        next_s.flg[FLG_DC] = lo_sum[4];
        next_s.flg[FLG_Z] = (full_sum[7:0] == 8'h00);
        next_s.flg[FLG_N] = full_sum[7];
        next_s.flg[FLG_OV] = (s.wreg[7] != mem_rdata[7])
                           && (full_sum[7] != s.wreg[7]);
        next_s.st = ST_Q4;
      end
      ST_Q4: begin
        if (s.dest) begin
          mem_we = 1'b1;
          mem_addr = s.addr;
          mem_wdata = s.res;
        end else begin
          next_s.wreg = s.res;
        end
        next_s.status[4:0] = s.flg;
        next_s.st = ST_IDLE;
      end
      default: begin
        next_s.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.instr <= RST_INSTR;
      s.wreg <= RST_WREG;
      s.status <= RST_STATUS;
      s.bank <= RST_BANK;
      s.idx <= RST_INDEX;
    end else begin
      s <= next_s;
    end
  end

  assign pready = s.pready;
  assign prdata = s.prdata;
  assign pslverr = s.pslverr;

  // ==========================================================
  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_PHASES: assert property (
    s.st == ST_Q2 |=> s.st == ST_Q3 ##1 s.st == ST_Q4 ##1 s.st == ST_IDLE)
    else $error("phase sequence broken");
  AST_DEST_W: assert property (
    s.st == ST_Q4 && !s.dest |=> s.wreg == $past(s.res))
    else $error("accumulator not written");
  AST_DEST_F: assert property (
    s.st == ST_Q4 && s.dest |-> mem_we && mem_wdata == s.res
      && mem_addr == s.addr)
    else $error("file byte not written");
  AST_ARITH: assert property (
    s.st == ST_Q3 |=> s.res == $past(s.wreg - mem_rdata
      - {7'h00, ~s.status[FLG_C]}))
    else $error("wrong difference");
  AST_BANKED: assert property (
    s.st == ST_Q1 && s.instr[15:10] == OPC_PREFIX && s.instr[INS_BANK]
      |=> mem_addr == {$past(s.bank), $past(ffield)})
    else $error("banked address wrong");
  AST_INDEXED: assert property (
    s.st == ST_Q1 && s.instr[15:10] == OPC_PREFIX && !s.instr[INS_BANK]
      && s.ext && ffield <= IDX_LIMIT
      |=> mem_addr == $past(s.idx) + {4'h0, $past(ffield)})
    else $error("indexed address wrong");
  AST_DECODE: assert property (
    s.st == ST_Q1 && s.instr[15:10] != OPC_PREFIX
      |=> s.st == ST_IDLE && s.illegal)
    else $error("foreign opcode executed");
  AST_KEEP: assert property (
    s.st == ST_Q4 |=> s.status[7:5] == $past(s.status[7:5]))
    else $error("unrelated status bit changed");
  AST_ZN: assert property (
    s.st == ST_Q4 |=> s.status[FLG_Z] == ($past(s.res) == 8'h00)
      && s.status[FLG_N] == $past(s.res[7]))
    else $error("zero or negative flag wrong");
  AST_START: assert property (
    apb_done && pwrite && !s.pslverr && paddr == OFF_CTRL
      && pwdata[CTRL_START] |=> s.st == ST_Q1)
    else $error("start write ignored");
  AST_CARRY: assert property (
    s.st == ST_Q3 |=> s.flg[FLG_C] == ({1'b0, $past(s.wreg)}
      >= {1'b0, $past(mem_rdata)} + {8'h00, ~$past(s.status[FLG_C])}))
    else $error("carry flag wrong");
  AST_NIBBLE: assert property (
    s.st == ST_Q3 |=> s.flg[FLG_DC] == ({1'b0, $past(s.wreg[3:0])}
      >= {1'b0, $past(mem_rdata[3:0])} + {4'h0, ~$past(s.status[FLG_C])}))
    else $error("nibble borrow flag wrong");
  AST_OVF: assert property (
    s.st == ST_Q3 |=> s.flg[FLG_OV] ==
      ($past(s.wreg[7]) != $past(mem_rdata[7])
      && s.res[7] != $past(s.wreg[7])))
    else $error("signed wrap flag wrong");
  AST_WIN_LOW: assert property (
    s.st == ST_Q1 && s.instr[15:10] == OPC_PREFIX && !s.instr[INS_BANK]
      && !s.ext && ffield <= IDX_LIMIT
      |=> mem_addr == {4'h0, $past(ffield)})
    else $error("low window address wrong");
  AST_WIN_HIGH: assert property (
    s.st == ST_Q1 && s.instr[15:10] == OPC_PREFIX && !s.instr[INS_BANK]
      && ffield > IDX_LIMIT
      |=> mem_addr == {WIN_HIGH_PAGE, $past(ffield)})
    else $error("high window address wrong");
  AST_DEST_W_ONLY: assert property (
    s.st == ST_Q4 && !s.dest |-> !mem_we)
    else $error("file byte written for accumulator result");
  AST_FLAGS: assert property (
    s.st == ST_Q4 |=> s.status[4:0] == $past(s.flg))
    else $error("flags not updated");
  AST_FOREIGN_QUIET: assert property (
    s.st == ST_Q1 && s.instr[15:10] != OPC_PREFIX
      |=> s.wreg == $past(s.wreg) && s.status == $past(s.status))
    else $error("foreign opcode changed state");

  COV_TO_W: cover property (s.st == ST_Q4 && !s.dest);
  COV_TO_F: cover property (s.st == ST_Q4 && s.dest);
  COV_ILLEGAL: cover property (s.st == ST_Q1 ##1 s.illegal);
  COV_ERR: cover property (apb_done && s.pslverr);

endmodule : swb_core

`default_nettype wire

// ### dv/swb_host.sv
// APB master model standing in for the host side of the core.
// Assumes one pclk domain; every transfer waits on pready.
`default_nettype none

module swb_host (
  // Clock
  input wire logic pclk,
  // Answer
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [swb_pkg::PADDR_W-1:0] paddr,
  output logic [31:0] pwdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // ==========================================================
  // Request held until pready is sampled high at an edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : swb_host

`default_nettype wire

// ### dv/tb_subtract_w_file_with_borrow.sv
// Self-checking bench for the subtract-with-borrow core.
// Assumes swb_pkg, swb_core and swb_host are compiled first.
`default_nettype none

module tb_subtract_w_file_with_borrow;
  import swb_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [PADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  int fail_count = 0;
  int tests_run = 0;
  logic [31:0] v;
  logic er;

  always #4 pclk = ~pclk;

  swb_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr));
  swb_host host_u (.pclk(pclk), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    host_u.xfer(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic e);
    host_u.xfer(1'b0, a, 32'h0, d, e);
  endtask : rd

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  // Loads operands, runs one instruction, checks both places and flags
  task automatic run(input logic d, input logic a, input logic ext,
                     input logic [7:0] f, input logic [7:0] w,
                     input logic [7:0] m, input logic [7:0] st,
                     input logic [11:0] ad);
    logic [8:0] df;
    logic [4:0] lo;
    logic [7:0] res, se;
    logic e;
    int n;
    df = {1'b0, w} - {1'b0, m} - {8'h0, ~st[0]};
    lo = {1'b0, w[3:0]} - {1'b0, m[3:0]} - {4'h0, ~st[0]};
    res = df[7:0];
    se = st;
    se[FLG_C] = ~df[8];
    se[FLG_DC] = ~lo[4];
    se[FLG_Z] = (res == 8'h00);
    se[FLG_N] = res[7];
    se[FLG_OV] = (w[7] != m[7]) && (res[7] != w[7]);
    wr(OFF_MADDR, {20'h0, ad});
    wr(OFF_MDATA, {24'h0, m});
    wr(OFF_WREG, {24'h0, w});
    wr(OFF_STATUS, {24'h0, st});
    wr(OFF_BANK, {28'h0, ad[11:8]});
    wr(OFF_INDEX, 32'h100);
    wr(OFF_INSTR, {16'h0, OPC_PREFIX, d, a, f});
    wr(OFF_CTRL, {30'h0, ext, 1'b1});
    n = 0;
    do begin
      rd(OFF_CTRL, v, e);
      n++;
    end while (v[CTRL_BUSY] !== 1'b0 && n < 50);
    chk(v[CTRL_BUSY], 1'b0);
    chk(v[CTRL_EXT], ext);
    rd(OFF_WREG, v, e);
    chk(v, d ? {24'h0, w} : {24'h0, res});
    rd(OFF_STATUS, v, e);
    chk(v, {24'h0, se});
    rd(OFF_MDATA, v, e);
    chk(v, d ? {24'h0, res} : {24'h0, m});
    $display("test at %0t finished", $time);
  endtask : run

  // ==========================================================
  // Main sequence
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFF_WREG, v, er);
    chk(v, 32'h0);
    rd(OFF_STATUS, v, er);
    chk(v, 32'h0);
    rd(8'h20, v, er);
    chk({31'h0, er}, 32'h1);
    run(1'b1, 1'b0, 1'b0, 8'h80, 8'h02, 8'h03, 8'he1, 12'hf80);
    run(1'b0, 1'b1, 1'b0, 8'h10, 8'h05, 8'h02, 8'h01, 12'h210);
    run(1'b1, 1'b0, 1'b0, 8'h5f, 8'h04, 8'h01, 8'h00, 12'h05f);
    run(1'b1, 1'b0, 1'b1, 8'h5f, 8'h33, 8'h44, 8'h01, 12'h15f);
    run(1'b1, 1'b0, 1'b1, 8'h60, 8'h90, 8'h10, 8'h00, 12'hf60);
    run(1'b0, 1'b1, 1'b0, 8'ha5, 8'h80, 8'h01, 8'h01, 12'h3a5);
    run(1'b1, 1'b1, 1'b0, 8'h00, 8'h10, 8'h0f, 8'h00, 12'h700);
    wr(OFF_WREG, 32'h5a);
    wr(OFF_INSTR, 32'h5800);
    wr(OFF_CTRL, 32'h1);
    repeat (6) @(posedge pclk);
    rd(OFF_CTRL, v, er);
    chk({31'h0, v[CTRL_ILLEGAL]}, 32'h1);
    rd(OFF_WREG, v, er);
    chk(v, 32'h5a);
    $display("test at %0t finished", $time);
    test_done();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    test_done();
  end
endmodule : tb_subtract_w_file_with_borrow

`default_nettype wire
